/* File: design/pcrc_pkg.sv */
package pcrc_pkg;
	// Register indexes; the AHB-Lite byte address is four times the index
	localparam logic [11:0] ADDR_CONTROL = 12'h640;
	localparam logic [11:0] ADDR_TAPS = 12'h642;
	localparam logic [11:0] ADDR_DATA = 12'h644;
	localparam logic [11:0] ADDR_RESULT = 12'h646;
	localparam logic [11:0] ADDR_IDLE = 12'h648;
	localparam logic [11:0] OFS_CONTROL = 12'h640;
	localparam logic [11:0] OFS_TAPS = 12'h650;
	localparam logic [11:0] OFS_DATA = 12'h660;
	localparam logic [11:0] OFS_RESULT = 12'h670;
	localparam logic [11:0] OFS_IDLE = 12'h680;
	// Control register field positions
	localparam int POS_IDLE_STOP = 13;
	localparam int POS_COUNT_LO = 8;
	localparam int POS_FULL = 7;
	localparam int POS_EMPTY = 6;
	localparam int POS_START = 4;
	localparam logic [15:0] CONTROL_WMASK = 16'h201f;
	localparam logic [15:0] RESET_TAPS = 16'h0000;
	localparam logic [15:0] RESET_DATA = 16'h0000;
	localparam logic [15:0] RESET_RESULT = 16'h0000;
	localparam logic [3:0] RESET_LEN = 4'h0;
	localparam logic [3:0] LEN_SPLIT = 4'h7;
	localparam logic [4:0] DEPTH_SHORT = 5'h10;
	localparam logic [4:0] DEPTH_LONG = 5'h08;
	localparam logic [4:0] BITS_PER_WORD = 5'h10;

	typedef struct packed {
		logic idle_stop;
		logic shifter_start;
		logic [3:0] poly_length_minus_one;
	} pcrc_ctrl_s;

	typedef enum logic [1:0] {PCRC_IDLE, PCRC_LOAD, PCRC_SHIFT} pcrc_state_e;
endpackage : pcrc_pkg

/* File: design/pcrc_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Idle stop set halts unit during idle
// - Bits 12:8 report valid FIFO words
// - Depth 8 if length field above 7, else 16
// - Bit 7 full flag, resets 0
// - Bit 6 empty flag, resets 1
// - Start bit lets shifter take FIFO words, zero stops it after the word in progress
// - Length field is polynomial length minus one
// - Bits 15, 14, 5 read zero
// - Data writes push into input FIFO, dropped while it is full
// - Result register holds computed CRC
module pcrc_top #(
	parameter int FIFO_AW = 4
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic idle_mode
);
	localparam int FIFO_DEPTH = 1 << FIFO_AW;

	pcrc_pkg::pcrc_ctrl_s ctrl;
	pcrc_pkg::pcrc_state_e state;
	pcrc_pkg::pcrc_state_e next_state;
	logic [15:0] taps;
	logic [15:0] data_in;
	logic [15:0] result;
	logic [4:0] count;
	logic [FIFO_AW-1:0] wr_ptr;
	logic [FIFO_AW-1:0] rd_ptr;
	logic [15:0] mem_rd;
	logic [15:0] shreg;
	logic [4:0] bit_cnt;
	logic idle_meta;
	logic idle_sync;
	logic dp_write;
	logic dp_read;
	logic [11:0] dp_addr;
	logic [4:0] depth_limit;
	logic fifo_full;
	logic fifo_empty;
	logic push;
	logic pop;
	logic halted;
	logic [15:0] control_rd;
	logic [15:0] read_word;
	logic addr_take;
	logic rd_pend;
	logic wr_control;
	logic wr_taps;
	logic wr_data;
	logic wr_result;
	logic shift_en;

	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic din,
		input logic [15:0] tp, input logic [3:0] len);
		logic fb;
		logic [15:0] nxt;
		fb = crc[len] ^ din;
		nxt = {crc[14:0], 1'b0};
		if (fb) begin
			nxt = nxt ^ tp;
		end
		nxt[0] = fb;
		return nxt;
	endfunction : crc_step

	// Register select on the word index carried in haddr[13:2]
	function automatic logic reg_hit(input logic [11:0] idx, input logic [11:0] reg_idx);
		return idx == reg_idx;
	endfunction : reg_hit

	function automatic logic [4:0] depth_for(input logic [3:0] len);
		return (len > pcrc_pkg::LEN_SPLIT) ? pcrc_pkg::DEPTH_LONG : pcrc_pkg::DEPTH_SHORT;
	endfunction : depth_for

	// Idle request comes from the power controller domain
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle_meta <= 1'b0;
			idle_sync <= 1'b0;
		end else begin
			idle_meta <= idle_mode;
			idle_sync <= idle_meta;
		end
	end

	assign halted = ctrl.idle_stop && idle_sync;

	// Address phase capture; haddr[13:2] is the register index
	assign addr_take = hready && hsel && htrans[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_read <= 1'b0;
			dp_addr <= 12'h000;
		end else if (hready) begin
			dp_write <= addr_take && hwrite;
			dp_read <= addr_take && !hwrite;
			dp_addr <= haddr[13:2];
		end
	end

	// One wait state on every read, so that a write landing
	// in the data phase just before is already visible
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_pend <= 1'b0;
		end else if (rd_pend) begin
			rd_pend <= 1'b0;
		end else begin
			rd_pend <= addr_take && !hwrite;
		end
	end

	assign hreadyout = !rd_pend;
	assign hresp = 1'b0;

	assign wr_control = dp_write && reg_hit(dp_addr, pcrc_pkg::ADDR_CONTROL);
	assign wr_taps = dp_write && reg_hit(dp_addr, pcrc_pkg::ADDR_TAPS);
	assign wr_data = dp_write && reg_hit(dp_addr, pcrc_pkg::ADDR_DATA);
	assign wr_result = dp_write && reg_hit(dp_addr, pcrc_pkg::ADDR_RESULT);

	assign depth_limit = depth_for(ctrl.poly_length_minus_one);
	assign fifo_full = (count >= depth_limit);
	assign fifo_empty = (count == 5'h00);
	// Writes to a full FIFO are dropped so no word is overwritten
	assign push = wr_data && !fifo_full;
	assign pop = (state == pcrc_pkg::PCRC_IDLE) && ctrl.shifter_start && !fifo_empty && !halted;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= '0;
			ctrl.poly_length_minus_one <= pcrc_pkg::RESET_LEN;
		end else if (wr_control) begin
			ctrl.idle_stop <= hwdata[pcrc_pkg::POS_IDLE_STOP];
			ctrl.shifter_start <= hwdata[pcrc_pkg::POS_START];
			ctrl.poly_length_minus_one <= hwdata[3:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			taps <= pcrc_pkg::RESET_TAPS;
		end else if (wr_taps) begin
			taps <= {hwdata[15:1], 1'b0};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_in <= pcrc_pkg::RESET_DATA;
		end else if (push) begin
			data_in <= hwdata[15:0];
		end
	end

	// FIFO pointers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	// Occupancy; a push and a pop in one cycle cancel
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= 5'h00;
		end else begin
			if (push && !pop) begin
				count <= count + 5'h01;
			end else if (pop && !push) begin
				count <= count - 5'h01;
			end
		end
	end

	pcrc_word_mem #(
		.WIDTH(16),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_mem (
		.hclk(hclk),
		.wr_en(push),
		.wr_addr(wr_ptr),
		.wr_data(hwdata[15:0]),
		.rd_addr(rd_ptr),
		.rd_data(mem_rd)
	);

	// Shifter sequencing: pop, wait one cycle for memory, then 16 shifts
	always_comb begin
		next_state = state;
		case (state)
			pcrc_pkg::PCRC_IDLE: begin
				if (pop) begin
					next_state = pcrc_pkg::PCRC_LOAD;
				end
			end
			pcrc_pkg::PCRC_LOAD: begin
				next_state = pcrc_pkg::PCRC_SHIFT;
			end
			pcrc_pkg::PCRC_SHIFT: begin
				if (!halted && bit_cnt == 5'h01) begin
					next_state = pcrc_pkg::PCRC_IDLE;
				end
			end
			default: begin
				next_state = pcrc_pkg::PCRC_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= pcrc_pkg::PCRC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign shift_en = (state == pcrc_pkg::PCRC_SHIFT) && !halted;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shreg <= 16'h0000;
			bit_cnt <= 5'h00;
		end else if (state == pcrc_pkg::PCRC_LOAD) begin
			shreg <= mem_rd;
			bit_cnt <= pcrc_pkg::BITS_PER_WORD;
		end else if (shift_en) begin
			shreg <= {shreg[14:0], 1'b0};
			bit_cnt <= bit_cnt - 5'h01;
		end
	end

	// A software write to the result seeds the CRC; shifting wins if both
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			result <= pcrc_pkg::RESET_RESULT;
		end else if (shift_en) begin
			result <= crc_step(result, shreg[15], taps, ctrl.poly_length_minus_one);
		end else if (wr_result) begin
			result <= hwdata[15:0];
		end
	end

	always_comb begin
		control_rd = 16'h0000;
		control_rd[pcrc_pkg::POS_IDLE_STOP] = ctrl.idle_stop;
		control_rd[12:8] = count;
		control_rd[pcrc_pkg::POS_FULL] = fifo_full;
		control_rd[pcrc_pkg::POS_EMPTY] = fifo_empty;
		control_rd[pcrc_pkg::POS_START] = ctrl.shifter_start;
		control_rd[3:0] = ctrl.poly_length_minus_one;
	end

	always_comb begin
		read_word = 16'h0000;
		case (dp_addr)
			pcrc_pkg::ADDR_CONTROL: read_word = control_rd;
			pcrc_pkg::ADDR_TAPS: read_word = taps;
			pcrc_pkg::ADDR_DATA: read_word = data_in;
			pcrc_pkg::ADDR_RESULT: read_word = result;
			default: read_word = 16'h0000;
		endcase
	end

	// Read data loaded at the end of the wait state, then stands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (rd_pend && dp_read) begin
			hrdata <= {16'h0000, read_word};
		end
	end
endmodule : pcrc_top

/* File: design/pcrc_word_mem.sv */
`timescale 1ns/1ps
module pcrc_word_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic hclk,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] store [DEPTH];

	always_ff @(posedge hclk) begin
		if (wr_en) begin
			store[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge hclk) begin
		rd_data <= store[rd_addr];
	end
endmodule : pcrc_word_mem

/* File: sim/pcrc_assertions.sv */
`timescale 1ns/1ps
module pcrc_assertions (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp
);
	logic rd_ctl, rd_tap, wr_ctl;
	logic [15:0] wctl;
	wire take = hready & hsel & htrans[1];
	wire [4:0] cnt = hrdata[12:8];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_ctl <= 1'b0;
			rd_tap <= 1'b0;
			wr_ctl <= 1'b0;
		end else begin
			rd_ctl <= take & !hwrite & haddr[13:2] == pcrc_pkg::ADDR_CONTROL;
			rd_tap <= take & !hwrite & haddr[13:2] == pcrc_pkg::ADDR_TAPS;
			wr_ctl <= take & hwrite & haddr[13:2] == pcrc_pkg::ADDR_CONTROL;
		end
	end
	// Shadow of the writable control bits, taken in the write data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) wctl <= 16'h0000;
		else if (wr_ctl) wctl <= hwdata[15:0] & pcrc_pkg::CONTROL_WMASK;
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Reads carry one wait state: read data stands in the cycle after rd_ctl
	a_unimpl_zero: assert property (rd_ctl |=> hrdata[15:14] == 2'h0 && !hrdata[5])
		else $error("reserved control bits set");
	a_count_empty: assert property (rd_ctl |=> (cnt == 5'h00) == hrdata[6])
		else $error("empty flag disagrees with count");
	a_full_depth: assert property (rd_ctl |=> hrdata[7] == (cnt >= (hrdata[3:0] > 4'h7 ? 5'h08 : 5'h10)))
		else $error("full flag disagrees with depth");
	a_flags_excl: assert property (rd_ctl |=> !(hrdata[7] && hrdata[6]))
		else $error("full and empty together");
	a_count_max: assert property (rd_ctl |=> cnt <= 5'h10)
		else $error("count above sixteen");
	a_ctl_kept: assert property (rd_ctl |=> hrdata[13] == wctl[13] && hrdata[4:0] == wctl[4:0])
		else $error("control bits differ from last write");
	a_taps_lsb: assert property (rd_tap |=> !hrdata[0])
		else $error("taps bit zero set");
	a_bus_okay: assert property (take |-> ##[1:2] (hreadyout && !hresp))
		else $error("slave stalled or erred");
	a_write_nowait: assert property (take && hwrite |=> hreadyout && !hresp)
		else $error("write data phase stalled");
endmodule : pcrc_assertions
bind pcrc_top pcrc_assertions u_pcrc_assertions (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .hrdata, .hreadyout, .hresp);

/* File: sim/pcrc_top_bench.sv */
`timescale 1ns/1ps
module pcrc_top_bench;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, idle_mode = 1'b0, got = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic hreadyout, hresp;
	logic [15:0] q[$];
	logic [15:0] seen, taps, crc, w;
	int n_mismatch = 0, compares = 0, seed = 32'hd27d, k;
	pcrc_top u_pcrc_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .idle_mode);
	always #12.5 hclk = ~hclk;
	task close_out;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : close_out
	task wait_rdy;
		int i;
		@(posedge hclk);
		for (i = 0; i < 50 && hreadyout !== 1'b1; i++) @(posedge hclk);
		if (i == 50) begin
			n_mismatch++;
			close_out();
		end
	endtask : wait_rdy
	task xfer(input logic wr, input logic [11:0] a, input logic [15:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {18'h0, a, 2'b00};
		wait_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {16'h0, d};
		wait_rdy();
		if (!wr) begin
			seen <= hrdata[15:0];
			got <= 1'b1;
		end
	endtask : xfer
	task rd(input logic [11:0] a, input logic [15:0] e);
		q.push_back(e);
		xfer(1'b0, a, 16'h0);
	endtask : rd
	// Read results are judged here, oldest expectation first
	task cmp_read;
		compares++;
		if (q.size() == 0 || seen !== q[0]) begin
			n_mismatch++;
			$display("unexpected hrdata expected %h seen %h", q[0], seen);
		end
		void'(q.pop_front());
	endtask : cmp_read
	always @(posedge hclk) begin
		if (got) begin
			got <= 1'b0;
			cmp_read();
		end
	end
	function automatic logic [15:0] step(input logic [15:0] r, input logic [15:0] d, input logic [15:0] t);
		logic fb;
		for (int i = 15; i >= 0; i--) begin
			fb = r[15] ^ d[i];
			r = {r[14:0], fb} ^ (fb ? t : 16'h0);
		end
		return r;
	endfunction : step
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(pcrc_pkg::ADDR_CONTROL, 16'h0040);
		xfer(1'b1, pcrc_pkg::ADDR_CONTROL, 16'hffff);
		rd(pcrc_pkg::ADDR_CONTROL, 16'h205f);
		xfer(1'b1, pcrc_pkg::ADDR_CONTROL, 16'h0008);
		// Ninth word must be dropped at depth eight
		for (k = 0; k < 9; k++) xfer(1'b1, pcrc_pkg::ADDR_DATA, 16'(k));
		rd(pcrc_pkg::ADDR_CONTROL, 16'h0888);
		xfer(1'b1, pcrc_pkg::ADDR_CONTROL, 16'h0007);
		rd(pcrc_pkg::ADDR_CONTROL, 16'h0807);
		for (k = 0; k < 8; k++) xfer(1'b1, pcrc_pkg::ADDR_DATA, 16'(k));
		rd(pcrc_pkg::ADDR_CONTROL, 16'h1087);
		idle_mode <= 1'b1;
		repeat (4) @(posedge hclk);
		xfer(1'b1, pcrc_pkg::ADDR_CONTROL, 16'h2017);
		repeat (40) @(posedge hclk);
		rd(pcrc_pkg::ADDR_CONTROL, 16'h3097);
		idle_mode <= 1'b0;
		repeat (400) @(posedge hclk);
		rd(pcrc_pkg::ADDR_CONTROL, 16'h2057);
		xfer(1'b1, pcrc_pkg::ADDR_CONTROL, 16'h000f);
		taps = 16'($random(seed));
		xfer(1'b1, pcrc_pkg::ADDR_TAPS, taps);
		rd(pcrc_pkg::ADDR_TAPS, taps & 16'hfffe);
		xfer(1'b1, pcrc_pkg::ADDR_RESULT, 16'h0000);
		crc = 16'h0000;
		for (k = 0; k < 8; k++) begin
			w = 16'($random(seed));
			xfer(1'b1, pcrc_pkg::ADDR_DATA, w);
			crc = step(crc, w, taps & 16'hfffe);
		end
		xfer(1'b1, pcrc_pkg::ADDR_CONTROL, 16'h001f);
		repeat (200) @(posedge hclk);
		rd(pcrc_pkg::ADDR_RESULT, crc);
		rd(pcrc_pkg::ADDR_CONTROL, 16'h005f);
		rd(12'h7f0, 16'h0000);
		repeat (3) @(posedge hclk);
		close_out();
	end
endmodule : pcrc_top_bench
